// [rtl/sabse_params.svh]
`ifndef SABSE_PARAMS_SVH
`define SABSE_PARAMS_SVH

// data path and storage
`define SABSE_DATA_W 8
`define SABSE_NIB_W 4
`define SABSE_ADDR_W 7
`define SABSE_FILE_DEPTH 128
`define SABSE_BIT_W 3
`define SABSE_LIT_W 9
`define SABSE_PC_W 15

// field positions
`define SABSE_MSB 7
`define SABSE_LSB 0

// reset values
`define SABSE_W_RST 8'h00
`define SABSE_FILE_RST 8'h00
`define SABSE_PC_RST 15'h0000
`define SABSE_FLAG_RST 1'b0

// program counter steps
`define SABSE_PC_STEP 15'h0001
`define SABSE_PC_SKIP 15'h0002

`endif

// [rtl/sabse_pkg.sv]
package sabse_pkg;

    typedef enum logic [2:0] {
        op_nop,
        arith_shift_right_file,
        add_with_carry_to_file,
        bit_clear_file,
        bit_test_skip_if_clear,
        bit_test_skip_if_set,
        pc_relative_jump
    } sabse_op_e;

    typedef logic [7:0] sabse_byte_t;

endpackage

// [rtl/sabse_core.sv]
`timescale 1ns/10ps
`include "sabse_params.svh"

module sabse_core (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // instruction issue
    input wire logic instr_valid,
    input wire sabse_pkg::sabse_op_e instr_op,
    input wire logic [`SABSE_ADDR_W-1:0] file_addr,
    input wire logic [`SABSE_BIT_W-1:0] bit_idx,
    input wire logic dest_sel,
    input wire logic [`SABSE_LIT_W-1:0] jump_lit,
    output logic instr_ready,
    output logic nop_cycle,
    // preload of accumulator and file registers
    input wire logic w_load_valid,
    input wire logic [`SABSE_DATA_W-1:0] w_load_data,
    input wire logic file_load_valid,
    input wire logic [`SABSE_ADDR_W-1:0] file_load_addr,
    input wire logic [`SABSE_DATA_W-1:0] file_load_data,
    // file register observation
    input wire logic [`SABSE_ADDR_W-1:0] file_rd_addr,
    output logic [`SABSE_DATA_W-1:0] file_rd_data,
    // architectural state
    output logic [`SABSE_DATA_W-1:0] w_out,
    output logic carry_flag,
    output logic nibble_overflow_flag,
    output logic zero_flag,
    output logic [`SABSE_PC_W-1:0] pc
);

    logic [`SABSE_DATA_W-1:0] file_mem [`SABSE_FILE_DEPTH];
    logic accept;
    logic [`SABSE_DATA_W-1:0] src;
    logic tested_bit;
    logic [`SABSE_DATA_W:0] sum9;
    logic [`SABSE_NIB_W:0] nib_sum;
    logic [`SABSE_DATA_W-1:0] next_result;
    logic [`SABSE_DATA_W-1:0] next_file;
    logic file_we_instr;
    logic skip_taken;
    logic two_cycle;
    logic [`SABSE_PC_W-1:0] lit_ext;
    logic [`SABSE_PC_W-1:0] next_pc;

    // shift and add choose their destination, the others never write the accumulator
    function automatic logic has_dest(input sabse_pkg::sabse_op_e op);
        has_dest = (op == sabse_pkg::arith_shift_right_file) ||
                   (op == sabse_pkg::add_with_carry_to_file);
    endfunction

    function automatic logic is_skip(input sabse_pkg::sabse_op_e op);
        is_skip = (op == sabse_pkg::bit_test_skip_if_clear) ||
                  (op == sabse_pkg::bit_test_skip_if_set);
    endfunction

    // issue is ignored during the substituted nop cycle
    assign accept = instr_valid && instr_ready;
    assign src = file_mem[file_addr];
    assign tested_bit = src[bit_idx];
    assign sum9 = {1'b0, w_out} + {1'b0, src} + {8'h00, carry_flag};
    assign nib_sum = {1'b0, w_out[`SABSE_NIB_W-1:0]} + {1'b0, src[`SABSE_NIB_W-1:0]}
                   + {4'h0, carry_flag};
    assign lit_ext = {{(`SABSE_PC_W-`SABSE_LIT_W){jump_lit[`SABSE_LIT_W-1]}}, jump_lit};

    always_comb begin
        next_result = `SABSE_W_RST;
        next_file = src;
        case (instr_op)
            sabse_pkg::arith_shift_right_file: begin
                next_result = {src[`SABSE_MSB], src[`SABSE_MSB:1]};
                next_file = next_result;
            end
            sabse_pkg::add_with_carry_to_file: begin
                next_result = sum9[`SABSE_DATA_W-1:0];
                next_file = next_result;
            end
            sabse_pkg::bit_clear_file: begin
                next_file = src & ~(8'h01 << bit_idx);
            end
            default: begin
                next_result = `SABSE_W_RST;
                next_file = src;
            end
        endcase
    end

    // skip on a cleared bit for one test, on a set bit for the other
    always_comb begin
        case (instr_op)
            sabse_pkg::bit_test_skip_if_clear: skip_taken = !tested_bit;
            sabse_pkg::bit_test_skip_if_set: skip_taken = tested_bit;
            default: skip_taken = 1'b0;
        endcase
    end

    assign two_cycle = skip_taken || (instr_op == sabse_pkg::pc_relative_jump);
    assign file_we_instr = accept && ((instr_op == sabse_pkg::bit_clear_file) ||
                                      (has_dest(instr_op) && dest_sel));

    always_comb begin
        next_pc = pc + `SABSE_PC_STEP;
        if (instr_op == sabse_pkg::pc_relative_jump) begin
            next_pc = pc + `SABSE_PC_STEP + lit_ext;
        end else if (skip_taken) begin
            // the discarded word sits at pc+1, so fetch resumes one further on
            next_pc = pc + `SABSE_PC_SKIP;
        end
    end

    // file registers; an instruction write beats a preload to the same entry
    for (genvar i = 0; i < `SABSE_FILE_DEPTH; i++) begin : g_file
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                file_mem[i] <= `SABSE_FILE_RST;
            end else if (file_we_instr && (file_addr == `SABSE_ADDR_W'(i))) begin
                file_mem[i] <= next_file;
            end else if (file_load_valid && (file_load_addr == `SABSE_ADDR_W'(i))) begin
                file_mem[i] <= file_load_data;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            file_rd_data <= `SABSE_FILE_RST;
        end else begin
            file_rd_data <= file_mem[file_rd_addr];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            w_out <= `SABSE_W_RST;
        end else if (accept && has_dest(instr_op) && !dest_sel) begin
            w_out <= next_result;
        end else if (w_load_valid) begin
            w_out <= w_load_data;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            carry_flag <= `SABSE_FLAG_RST;
            nibble_overflow_flag <= `SABSE_FLAG_RST;
            zero_flag <= `SABSE_FLAG_RST;
        end else if (accept && (instr_op == sabse_pkg::arith_shift_right_file)) begin
            carry_flag <= src[`SABSE_LSB];
            zero_flag <= (next_result == 8'h00);
        end else if (accept && (instr_op == sabse_pkg::add_with_carry_to_file)) begin
            carry_flag <= sum9[`SABSE_DATA_W];
            nibble_overflow_flag <= nib_sum[`SABSE_NIB_W];
            zero_flag <= (next_result == 8'h00);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pc <= `SABSE_PC_RST;
        end else if (accept) begin
            pc <= next_pc;
        end
    end

    // the second cycle executes as a nop; no new instruction is taken in it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            instr_ready <= 1'b1;
            nop_cycle <= 1'b0;
        end else if (accept && two_cycle) begin
            instr_ready <= 1'b0;
            nop_cycle <= 1'b1;
        end else begin
            instr_ready <= 1'b1;
            nop_cycle <= 1'b0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence nop_then_ready;
        (!instr_ready && nop_cycle) ##1 (instr_ready && !nop_cycle);
    endsequence

    sequence single_cycle;
        instr_ready && !nop_cycle;
    endsequence

    function automatic logic is_op(input sabse_pkg::sabse_op_e op,
                                   input sabse_pkg::sabse_op_e want);
        is_op = (op == want);
    endfunction

    asr_shape_a: assert property (
        accept && is_op(instr_op, sabse_pkg::arith_shift_right_file) && !dest_sel
        |=> (w_out == {$past(src[`SABSE_MSB]), $past(src[`SABSE_MSB:1])}) &&
            (carry_flag == $past(src[`SABSE_LSB])))
        else $error("shift result or carry wrong");

    asr_file_dest_a: assert property (
        accept && is_op(instr_op, sabse_pkg::arith_shift_right_file) && dest_sel
        |=> (file_mem[$past(file_addr)] == {$past(src[`SABSE_MSB]), $past(src[`SABSE_MSB:1])})
            && $stable(w_out))
        else $error("shift to file went astray");

    add_w_dest_a: assert property (
        accept && is_op(instr_op, sabse_pkg::add_with_carry_to_file) && !dest_sel
        |=> (w_out == $past(w_out + src + {7'h00, carry_flag})) &&
            (carry_flag == $past(({1'b0, w_out} + {1'b0, src} + {8'h00, carry_flag}) > 9'h0ff)))
        else $error("add with carry to accumulator wrong");

    add_file_dest_a: assert property (
        accept && is_op(instr_op, sabse_pkg::add_with_carry_to_file) && dest_sel
        |=> (file_mem[$past(file_addr)] == $past(w_out + src + {7'h00, carry_flag})) &&
            $stable(w_out))
        else $error("add with carry to file wrong");

    add_flags_a: assert property (
        accept && is_op(instr_op, sabse_pkg::add_with_carry_to_file)
        |=> (zero_flag == ($past(w_out + src + {7'h00, carry_flag}) == 8'h00)) &&
            (nibble_overflow_flag ==
             ($past({1'b0, w_out[3:0]} + {1'b0, src[3:0]} + {4'h0, carry_flag}) > 5'h0f)))
        else $error("zero or nibble carry wrong after add");

    bit_clear_a: assert property (
        accept && is_op(instr_op, sabse_pkg::bit_clear_file)
        |=> (file_mem[$past(file_addr)] == ($past(src) & ~(8'h01 << $past(bit_idx)))) &&
            $stable(carry_flag) && $stable(zero_flag) && $stable(nibble_overflow_flag))
        else $error("bit clear wrong or flags moved");

    clear_no_skip_a: assert property (
        accept && is_op(instr_op, sabse_pkg::bit_test_skip_if_clear) && tested_bit
        |=> single_cycle and (pc == $past(pc) + `SABSE_PC_STEP))
        else $error("skip-if-clear skipped on a set bit");

    clear_skip_a: assert property (
        accept && is_op(instr_op, sabse_pkg::bit_test_skip_if_clear) && !tested_bit
        |=> nop_then_ready and (pc == $past(pc) + `SABSE_PC_SKIP))
        else $error("skip-if-clear did not skip on a clear bit");

    set_no_skip_a: assert property (
        accept && is_op(instr_op, sabse_pkg::bit_test_skip_if_set) && !tested_bit
        |=> single_cycle and (pc == $past(pc) + `SABSE_PC_STEP))
        else $error("skip-if-set skipped on a clear bit");

    set_skip_a: assert property (
        accept && is_op(instr_op, sabse_pkg::bit_test_skip_if_set) && tested_bit
        |=> nop_then_ready and (pc == $past(pc) + `SABSE_PC_SKIP))
        else $error("skip-if-set did not skip on a set bit");

    jump_target_a: assert property (
        accept && is_op(instr_op, sabse_pkg::pc_relative_jump)
        |=> pc == $past(pc) + `SABSE_PC_STEP + $past(`SABSE_PC_W'($signed(jump_lit))))
        else $error("relative jump target wrong");

    jump_timing_a: assert property (
        accept && is_op(instr_op, sabse_pkg::pc_relative_jump)
        |=> nop_then_ready and ($stable(carry_flag) && $stable(zero_flag) &&
                                $stable(nibble_overflow_flag))[*2])
        else $error("relative jump timing or flags wrong");

    skip_flags_a: assert property (
        accept && is_skip(instr_op)
        |=> $stable(carry_flag) && $stable(zero_flag) && $stable(w_out))
        else $error("bit test changed state");

endmodule

// [verif/shift_add_bit_skip_branch_exec_tb_top.sv]
`timescale 1ns/10ps

module shift_add_bit_skip_branch_exec_tb_top;
    localparam sabse_pkg::sabse_op_e op_sh = sabse_pkg::arith_shift_right_file;
    localparam sabse_pkg::sabse_op_e op_ad = sabse_pkg::add_with_carry_to_file;
    localparam sabse_pkg::sabse_op_e op_bc = sabse_pkg::bit_clear_file;
    localparam sabse_pkg::sabse_op_e op_sc = sabse_pkg::bit_test_skip_if_clear;
    localparam sabse_pkg::sabse_op_e op_ss = sabse_pkg::bit_test_skip_if_set;
    localparam sabse_pkg::sabse_op_e op_j = sabse_pkg::pc_relative_jump;
    localparam sabse_pkg::sabse_op_e op_n = sabse_pkg::op_nop;
    // carry in, dest, then expected carry, nibble, zero, two-cycle
    typedef struct packed {logic cin; logic d; logic ec;
                           logic edc; logic ez; logic two;} sabse_fl_s;
    typedef struct {
        sabse_pkg::sabse_op_e op;
        logic [7:0] w, f, ew, ef;
        logic [6:0] a;
        logic [2:0] b;
        logic [8:0] lit;
        sabse_fl_s fl;
    } sabse_row_s;
    sabse_row_s rows [15] = '{
        '{op_sh, 8'h5a, 8'h81, 8'hc0, 8'h81, 7'h01, 3'h0, 9'h000, 6'b001000},
        '{op_sh, 8'h5a, 8'h01, 8'h5a, 8'h00, 7'h05, 3'h0, 9'h000, 6'b011010},
        '{op_sh, 8'h5a, 8'h40, 8'h5a, 8'h20, 7'h00, 3'h0, 9'h000, 6'b110000},
        '{op_ad, 8'h0f, 8'h00, 8'h10, 8'h00, 7'h03, 3'h0, 9'h000, 6'b100100},
        '{op_ad, 8'h80, 8'h80, 8'h80, 8'h00, 7'h7f, 3'h0, 9'h000, 6'b011010},
        '{op_ad, 8'hff, 8'h00, 8'hff, 8'h00, 7'h40, 3'h0, 9'h000, 6'b111110},
        '{op_bc, 8'h33, 8'hff, 8'h33, 8'h7f, 7'h09, 3'h7, 9'h000, 6'b101010},
        '{op_bc, 8'h33, 8'hff, 8'h33, 8'hfe, 7'h09, 3'h0, 9'h000, 6'b010010},
        '{op_sc, 8'h33, 8'hff, 8'h33, 8'hff, 7'h11, 3'h3, 9'h000, 6'b000010},
        '{op_sc, 8'h33, 8'hf7, 8'h33, 8'hf7, 7'h11, 3'h3, 9'h000, 6'b101011},
        '{op_ss, 8'h33, 8'h00, 8'h33, 8'h00, 7'h12, 3'h7, 9'h000, 6'b000010},
        '{op_ss, 8'h33, 8'h80, 8'h33, 8'h80, 7'h12, 3'h7, 9'h000, 6'b000011},
        '{op_j, 8'h33, 8'h00, 8'h33, 8'h00, 7'h00, 3'h0, 9'h0ff, 6'b101011},
        '{op_j, 8'h33, 8'h00, 8'h33, 8'h00, 7'h00, 3'h0, 9'h100, 6'b000011},
        '{op_n, 8'h33, 8'h00, 8'h33, 8'h00, 7'h00, 3'h0, 9'h000, 6'b101010}
    };
    logic clk = 1'b0, rstn = 1'b0, instr_valid = 1'b0, dest_sel = 1'b0;
    logic w_load_valid = 1'b0, file_load_valid = 1'b0;
    sabse_pkg::sabse_op_e instr_op = sabse_pkg::op_nop;
    logic [6:0] file_addr = 7'h00, file_load_addr = 7'h00, file_rd_addr = 7'h00;
    logic [2:0] bit_idx = 3'h0;
    logic [8:0] jump_lit = 9'h000;
    logic [7:0] w_load_data = 8'h00, file_load_data = 8'h00, file_rd_data, w_out;
    logic instr_ready, nop_cycle, carry_flag, nibble_overflow_flag, zero_flag;
    logic [14:0] pc, exp_pc = 15'h0000;
    logic cur_dc = 1'b0;
    int n_fail = 0, cmp_count = 0;
    sabse_row_s r;

    sabse_core sabse_core_i (
        .clk(clk), .rstn(rstn), .instr_valid(instr_valid), .instr_op(instr_op),
        .file_addr(file_addr), .bit_idx(bit_idx), .dest_sel(dest_sel), .jump_lit(jump_lit),
        .instr_ready(instr_ready), .nop_cycle(nop_cycle), .w_load_valid(w_load_valid),
        .w_load_data(w_load_data), .file_load_valid(file_load_valid),
        .file_load_addr(file_load_addr), .file_load_data(file_load_data),
        .file_rd_addr(file_rd_addr), .file_rd_data(file_rd_data), .w_out(w_out),
        .carry_flag(carry_flag), .nibble_overflow_flag(nibble_overflow_flag),
        .zero_flag(zero_flag), .pc(pc)
    );

    initial begin
        forever #25 clk = ~clk;
    end

    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk1(input string n, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic chk15(input string n, input logic [14:0] e, input logic [14:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic load(input logic [6:0] a, input logic [7:0] fv, input logic [7:0] wv);
        @(posedge clk);
        file_load_valid <= 1'b1;
        file_load_addr <= a;
        file_load_data <= fv;
        w_load_valid <= 1'b1;
        w_load_data <= wv;
        @(posedge clk);
        file_load_valid <= 1'b0;
        w_load_valid <= 1'b0;
    endtask

    // leaves the caller just after the edge that takes the instruction
    task automatic issue(input sabse_pkg::sabse_op_e op, input logic [6:0] a,
                         input logic [2:0] b, input logic d, input logic [8:0] lit);
        for (int i = 0; i < 4 && instr_ready !== 1'b1; i++) @(posedge clk);
        if (instr_ready !== 1'b1) begin
            n_fail++;
            end_sim();
        end
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_op <= op;
        file_addr <= a;
        bit_idx <= b;
        dest_sel <= d;
        jump_lit <= lit;
        file_rd_addr <= a;
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
    endtask

    task automatic chk_rst();
        chk8("w_out", 8'h00, w_out);
        chk8("file", 8'h00, file_rd_data);
        chk15("pc", 15'h0000, pc);
        chk1("carry", 1'b0, carry_flag);
        chk1("nibble", 1'b0, nibble_overflow_flag);
        chk1("zero", 1'b0, zero_flag);
        chk1("ready", 1'b1, instr_ready);
        chk1("nop", 1'b0, nop_cycle);
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        chk_rst();
        $display("reset test done");
        foreach (rows[i]) begin
            r = rows[i];
            // carry can only be set through an instruction, so shift it in first
            load(7'h7f, {7'h00, r.fl.cin}, r.w);
            issue(op_sh, 7'h7f, 3'h0, 1'b1, 9'h000);
            exp_pc = exp_pc + 15'h0001;
            load(r.a, r.f, r.w);
            issue(r.op, r.a, r.b, r.fl.d, r.lit);
            exp_pc = exp_pc + ((r.op == op_j) ? 15'h0001 + {{6{r.lit[8]}}, r.lit}
                                               : (r.fl.two ? 15'h0002 : 15'h0001));
            cur_dc = (r.op == op_ad) ? r.fl.edc : cur_dc;
            chk8("w_out", r.ew, w_out);
            chk1("carry", r.fl.ec, carry_flag);
            chk1("nibble", cur_dc, nibble_overflow_flag);
            chk1("zero", r.fl.ez, zero_flag);
            chk15("pc", exp_pc, pc);
            chk1("ready", !r.fl.two, instr_ready);
            chk1("nop", r.fl.two, nop_cycle);
            @(posedge clk);
            #1;
            chk8("file", r.ef, file_rd_data);
            chk1("ready", 1'b1, instr_ready);
            $display("row %0d done", i);
        end
        // instruction held over the substituted cycle must be ignored
        load(7'h15, 8'h01, 8'h10);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_op <= op_j;
        jump_lit <= 9'h000;
        @(posedge clk);
        instr_op <= op_ad;
        file_addr <= 7'h15;
        dest_sel <= 1'b0;
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
        exp_pc = exp_pc + 15'h0001;
        chk15("pc", exp_pc, pc);
        chk8("w_out", 8'h10, w_out);
        $display("refused test done");
        // back-to-back shifts, second must see the first result
        load(7'h14, 8'h81, 8'h00);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_op <= op_sh;
        file_addr <= 7'h14;
        dest_sel <= 1'b1;
        file_rd_addr <= 7'h14;
        repeat (2) @(posedge clk);
        instr_valid <= 1'b0;
        exp_pc = exp_pc + 15'h0002;
        @(posedge clk);
        #1;
        chk8("file", 8'he0, file_rd_data);
        chk1("carry", 1'b0, carry_flag);
        chk15("pc", exp_pc, pc);
        $display("back to back test done");
        @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        #1;
        chk_rst();
        @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        chk_rst();
        $display("mid-run reset test done");
        end_sim();
    end
endmodule
